// ==== hdl/cor_config_regs.sv ====
// Purpose: Upper output configuration registers of a clock synthesizer.
// Assumes: A serial management engine on ref_clk presents decoded byte accesses.
// Notes: Divider codes are decoded to plain ratios; reserved codes flag invalid.
//        A write lands on the edge that takes it; a read answer is registered on that same edge.
//
// Overview of operation
// - Bit 2 set skips retune sequence.
// - Bit 7 picks serial-ATA clock PLL source.
// - Processor divider codes map to ratios 2..12.
// - PCI Express divider codes map to 4..10.
`timescale 1ns/100ps

module cor_config_regs (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Byte access from the serial engine.
    input wire cor_pkg::cor_req_t req,
    output cor_pkg::cor_rsp_t rsp,
    // Configuration to the clock generation logic.
    output cor_pkg::cor_cfg_t cfg
);
    import cor_pkg::*;

    // ****************************************************************
    // Storage and decode
    // ****************************************************************
    logic [7:0] strengthReg;
    logic [7:0] slewReg;
    logic [7:0] syncReg;
    logic [7:0] procDivReg;
    logic [7:0] pcieDivReg;
    logic [7:0] next_rdData;
    logic [2:0] procCode;
    logic [2:0] pcieCode;
    logic [3:0] procRatio;
    logic [3:0] pcieRatio;

    // Address decode is shared by writes and reads.
    wire hitStrength = (req.addr == OFS_STRENGTH_RETUNE);
    wire hitSlew = (req.addr == OFS_SLEW_RATE);
    wire hitSync = (req.addr == OFS_SOURCE_SYNC);
    wire hitProc = (req.addr == OFS_PROC_DIV);
    wire hitPcie = (req.addr == OFS_PCIE_DIV);

    // Read selection; unmapped indices read as zero.
    assign next_rdData = hitStrength ? (strengthReg & MASK_STRENGTH_RETUNE) :
                         hitSlew ? slewReg :
                         hitSync ? syncReg :
                         hitProc ? procDivReg :
                         hitPcie ? pcieDivReg : 8'h00;

    // All eight bits are stored, except bit 5 of the strength register, so software sees back what it wrote.
    // A combined write and read returns the old byte, as the read selects before the edge.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            strengthReg <= RST_STRENGTH_RETUNE;
            slewReg <= RST_SLEW_RATE;
            syncReg <= RST_SOURCE_SYNC;
            procDivReg <= RST_PROC_DIV;
            pcieDivReg <= RST_PCIE_DIV;
        end else if (req.wrEn) begin
            if (hitStrength) strengthReg <= req.wrData & MASK_STRENGTH_RETUNE;
            if (hitSlew) slewReg <= req.wrData;
            if (hitSync) syncReg <= req.wrData;
            if (hitProc) procDivReg <= req.wrData;
            if (hitPcie) pcieDivReg <= req.wrData;
        end
    end

    // Read data is registered, so it is stable for the whole next cycle.
    // Read data loads only on a read, so it keeps the last answer between reads.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rsp <= '0;
        end else begin
            rsp.rdValid <= req.rdEn;
            if (req.rdEn) rsp.rdData <= next_rdData;
        end
    end

    // ****************************************************************
    // Divider ratio decode
    // ****************************************************************
    assign procCode = procDivReg[BIT_DIV_HI:BIT_DIV_LO];
    assign pcieCode = pcieDivReg[BIT_DIV_HI:BIT_DIV_LO];

    // Reserved codes give ratio zero rather than guessing at a divide value.
    // Downstream logic must test the valid flag before it trusts a ratio.
    always_comb begin
        unique case (procCode)
            3'h0: procRatio = 4'h2;
            3'h1: procRatio = 4'h3;
            3'h2: procRatio = 4'h4;
            3'h3: procRatio = 4'h6;
            3'h4: procRatio = 4'h8;
            3'h5: procRatio = 4'hc;
            default: procRatio = 4'h0;
        endcase
    end

    always_comb begin
        unique case (pcieCode)
            3'h0: pcieRatio = 4'h4;
            3'h1: pcieRatio = 4'h5;
            3'h2: pcieRatio = 4'h8;
            3'h3: pcieRatio = 4'ha;
            default: pcieRatio = 4'h0;
        endcase
    end

    // Bit and slew fields are straight taps of the stored registers; ratios and valid flags come from the decode.
    assign cfg.usbClockDriveStrength = strengthReg[BIT_USB_STRENGTH];
    assign cfg.bypassRetuneSequence = strengthReg[BIT_BYPASS_RETUNE];
    assign cfg.usbClockSlewField = slewReg[BIT_USB_SLEW_HI:BIT_USB_SLEW_LO];
    assign cfg.refClockSlewField = slewReg[BIT_REF_SLEW_HI:BIT_REF_SLEW_LO];
    assign cfg.serialAtaClockSourceSelect = syncReg[BIT_SATA_SOURCE];
    assign cfg.processorRatio = procRatio;
    assign cfg.processorRatioValid = (procRatio != 4'h0);
    assign cfg.pcieRatio = pcieRatio;
    assign cfg.pcieRatioValid = (pcieRatio != 4'h0);

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Each write must reach its configuration output on the very next edge.
    a_retune_bypass_write: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_STRENGTH_RETUNE)
            |=> cfg.bypassRetuneSequence == $past(req.wrData[2]))
        else $error("Retune bypass did not follow the write.");

    a_sata_source_write: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_SOURCE_SYNC)
            |=> cfg.serialAtaClockSourceSelect == $past(req.wrData[7]))
        else $error("Serial-ATA source select did not follow the write.");

    a_proc_ratio_map: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_PROC_DIV && req.wrData[2:0] == 3'h5)
            |=> cfg.processorRatio == 4'hc && cfg.processorRatioValid)
        else $error("Processor code 5 did not give a ratio of twelve.");

    a_pcie_ratio_map: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_PCIE_DIV && req.wrData[2:0] == 3'h3)
            |=> cfg.pcieRatio == 4'ha && cfg.pcieRatioValid)
        else $error("PCI Express code 3 did not give a ratio of ten.");

    // A write followed at once by a read of the processor divider byte must return the byte intact.
    a_reserved_readback: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_PROC_DIV)
            ##1 (req.rdEn && !req.wrEn && req.addr == OFS_PROC_DIV)
            |=> rsp.rdValid && rsp.rdData == $past(req.wrData, 2))
        else $error("Processor divider byte did not read back as written.");

    a_reserved_code_flag: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_PCIE_DIV && req.wrData[2])
            |=> !cfg.pcieRatioValid && cfg.pcieRatio == 4'h0)
        else $error("Reserved PCI Express code was not flagged.");

    // Reset values are checked from the second edge of reset on, since the first edge
    // may meet registers that the asynchronous reset has not yet reached.
    a_retune_reset_clear: assert property (
        @(posedge ref_clk)
        (reset ##1 reset)
            |-> !cfg.bypassRetuneSequence)
        else $error("Retune bypass was not cleared by reset.");

    a_sata_reset_clear: assert property (
        @(posedge ref_clk)
        (reset ##1 reset)
            |-> !cfg.serialAtaClockSourceSelect)
        else $error("Serial-ATA source select was not cleared by reset.");

    // Only a write to the owning byte may move a setting; a stray change would
    // retune a clock that is already running.
    a_retune_bypass_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        !(req.wrEn && req.addr == OFS_STRENGTH_RETUNE)
            |=> $stable(cfg.bypassRetuneSequence))
        else $error("Retune bypass moved without a write.");

    a_sata_source_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        !(req.wrEn && req.addr == OFS_SOURCE_SYNC)
            |=> $stable(cfg.serialAtaClockSourceSelect))
        else $error("Serial-ATA source select moved without a write.");

    a_proc_ratio_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        !(req.wrEn && req.addr == OFS_PROC_DIV)
            |=> $stable(cfg.processorRatio))
        else $error("Processor ratio moved without a write.");

    a_pcie_ratio_hold: assert property (
        @(posedge ref_clk) disable iff (reset)
        !(req.wrEn && req.addr == OFS_PCIE_DIV)
            |=> $stable(cfg.pcieRatio))
        else $error("PCI Express ratio moved without a write.");

    // The lowest code of each divider must give the smallest ratio of its table.
    a_proc_ratio_low: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_PROC_DIV && req.wrData[2:0] == 3'h0)
            |=> cfg.processorRatio == 4'h2 && cfg.processorRatioValid)
        else $error("Processor code 0 did not give a ratio of two.");

    a_pcie_ratio_low: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_PCIE_DIV && req.wrData[2:0] == 3'h0)
            |=> cfg.pcieRatio == 4'h4 && cfg.pcieRatioValid)
        else $error("PCI Express code 0 did not give a ratio of four.");

    // Processor codes six and seven have no ratio, so the output must say so.
    a_proc_reserved_flag: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wrEn && req.addr == OFS_PROC_DIV && req.wrData[2:1] == 2'h3)
            |=> !cfg.processorRatioValid && cfg.processorRatio == 4'h0)
        else $error("Reserved processor code was not flagged.");

    // Every read gives exactly one valid pulse, on the following edge.
    a_read_valid_pulse: assert property (
        @(posedge ref_clk) disable iff (reset)
        1'h1
            |=> rsp.rdValid == $past(req.rdEn))
        else $error("Read valid did not follow the read strobe.");

endmodule // cor_config_regs

// ==== hdl/cor_pkg.sv ====
// Purpose: Shared constants and types for the clock output configuration registers.
// Assumes: Byte-wide registers addressed by an 8-bit register index.
// Notes: Offsets are the register indices used by the serial management engine.
package cor_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_STRENGTH_RETUNE = 8'h14;
    localparam logic [7:0] OFS_SLEW_RATE = 8'h15;
    localparam logic [7:0] OFS_SOURCE_SYNC = 8'h16;
    localparam logic [7:0] OFS_PROC_DIV = 8'h1c;
    localparam logic [7:0] OFS_PCIE_DIV = 8'h1d;

    // ****************************************************************
    // Reset values and write masks
    // ****************************************************************
    localparam logic [7:0] RST_STRENGTH_RETUNE = 8'h00;
    localparam logic [7:0] RST_SLEW_RATE = 8'h74;
    localparam logic [7:0] RST_SOURCE_SYNC = 8'h00;
    localparam logic [7:0] RST_PROC_DIV = 8'h00;
    localparam logic [7:0] RST_PCIE_DIV = 8'h00;
    // Bit 5 of the strength register is read-only and reads as zero.
    localparam logic [7:0] MASK_STRENGTH_RETUNE = 8'hdf;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_USB_STRENGTH = 7;
    localparam int BIT_BYPASS_RETUNE = 2;
    localparam int BIT_USB_SLEW_HI = 7;
    localparam int BIT_USB_SLEW_LO = 6;
    localparam int BIT_REF_SLEW_HI = 5;
    localparam int BIT_REF_SLEW_LO = 4;
    localparam int BIT_SATA_SOURCE = 7;
    localparam int BIT_DIV_HI = 2;
    localparam int BIT_DIV_LO = 0;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } cor_req_t;

    typedef struct packed {
        logic rdValid;
        logic [7:0] rdData;
    } cor_rsp_t;

    typedef struct packed {
        logic usbClockDriveStrength;
        logic bypassRetuneSequence;
        logic [1:0] usbClockSlewField;
        logic [1:0] refClockSlewField;
        logic serialAtaClockSourceSelect;
        logic [3:0] processorRatio;
        logic processorRatioValid;
        logic [3:0] pcieRatio;
        logic pcieRatioValid;
    } cor_cfg_t;

endpackage

// ==== testbench/clock_output_config_regs_bench.sv ====
// Purpose: Self-checking bench for the configuration registers.
// Assumes: The host model makes every access.
// Notes: A row packs address, write data, readback and a cfg probe byte.
`timescale 1ns/100ps
module clock_output_config_regs_bench;
    import cor_pkg::*;
    logic ref_clk;
    logic reset;
    cor_req_t req;
    cor_rsp_t rsp;
    cor_cfg_t cfg;
    cor_rsp_t got;
    int err_total = 0;
    int tests_run = 0;
    // Reserved codes and bits are written too, so storage of them is seen.
    logic [31:0] rows [25] = '{32'h1cf8f812, 32'h1c010113, 32'h1c020214, 32'h1c030316,
        32'h1c040418, 32'h1c05051c, 32'h1c060600, 32'h1cffff00, 32'h1d000014, 32'h1d090915,
        32'h1d020218, 32'h1d03031a, 32'h1d040400, 32'h1d050500, 32'h1d060600, 32'h1d070700,
        32'h14040401, 32'h14ffdf03, 32'h14000000, 32'h16808001, 32'h167f7f00, 32'h15000000,
        32'h15c3c30c, 32'h17a50000, 32'h13ff0000};
    logic [31:0] rstRows [5] = '{32'h14000000, 32'h15007407, 32'h16000000, 32'h1c000012,
        32'h1d000014};
    cor_config_regs u_cor_config_regs (.ref_clk(ref_clk), .reset(reset), .req(req),
        .rsp(rsp), .cfg(cfg));
    cor_host_model u_cor_host_model (.ref_clk(ref_clk), .req(req), .rsp(rsp));
    // A 50 ns clock.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Gathers the cfg fields that belong to one register index.
    function automatic logic [7:0] probe(input logic [7:0] a);
        case (a)
            OFS_STRENGTH_RETUNE: probe = {6'h0, cfg.usbClockDriveStrength,
                cfg.bypassRetuneSequence};
            OFS_SLEW_RATE: probe = {4'h0, cfg.usbClockSlewField, cfg.refClockSlewField};
            OFS_SOURCE_SYNC: probe = {7'h0, cfg.serialAtaClockSourceSelect};
            OFS_PROC_DIV: probe = {3'h0, cfg.processorRatioValid, cfg.processorRatio};
            OFS_PCIE_DIV: probe = {3'h0, cfg.pcieRatioValid, cfg.pcieRatio};
            default: probe = 8'h00;
        endcase
    endfunction
    // Case equality keeps an unknown from passing.
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Optional write, cfg probe, then a read back.
    task automatic run(input logic [31:0] rw, input logic w);
        if (w) u_cor_host_model.acc(1'b1, 1'b0, rw[31:24], rw[23:16], got);
        chk("cfg", probe(rw[31:24]), rw[7:0]);
        u_cor_host_model.acc(1'b0, 1'b1, rw[31:24], 8'h00, got);
        chk("rdData", got.rdData, rw[15:8]);
        chk("rdValid", {7'h0, got.rdValid}, 8'h01);
    endtask
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Main sequence.
    initial begin
        reset = 1'b1;
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (rows[i]) run(rows[i], 1'b1);
        $display("Row tests done");
        @(posedge ref_clk);
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        foreach (rstRows[i]) run(rstRows[i], 1'b0);
        $display("Reset tests done");
        // A write and read together must return the old byte.
        u_cor_host_model.acc(1'b1, 1'b1, OFS_SOURCE_SYNC, 8'h80, got);
        chk("rdOld", got.rdData, 8'h00);
        chk("cfgNew", probe(OFS_SOURCE_SYNC), 8'h01);
        @(posedge ref_clk);
        #1 chk("rdPulse", {7'h0, rsp.rdValid}, 8'h00);
        $display("Overlap tests done");
        // A reserved divider code written and read back with no idle cycle between.
        u_cor_host_model.wr_then_rd(OFS_PROC_DIV, 8'he7, got);
        chk("rdBackToBack", got.rdData, 8'he7);
        chk("rdValidB2b", {7'h0, got.rdValid}, 8'h01);
        chk("cfgReserved", probe(OFS_PROC_DIV), 8'h00);
        $display("Back-to-back tests done");
        summarize();
    end
    // The run needs about 125 cycles; this cuts a hang short.
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        $display("Watchdog expired");
        summarize();
    end
endmodule // clock_output_config_regs_bench

// ==== testbench/cor_host_model.sv ====
// Purpose: Host model issuing byte accesses to the configuration registers.
// Assumes: Requests change only just after a rising ref_clk edge.
// Notes: Released lines carry inverted values so stale data never matches.
`timescale 1ns/100ps
module cor_host_model (
    // Clock.
    input wire logic ref_clk,
    // Access out, answer in.
    output cor_pkg::cor_req_t req,
    input wire cor_pkg::cor_rsp_t rsp
);
    import cor_pkg::*;
    // The bus idles with both strobes low.
    initial req = '0;
    // One strobe cycle, then release and take the registered answer.
    task automatic acc(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d, output cor_rsp_t got);
        @(posedge ref_clk);
        req <= '{w, r, a, d};
        @(posedge ref_clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
        #1 got = rsp;
    endtask
    // Write, then read the same index on the next edge with no idle cycle between.
    task automatic wr_then_rd(input logic [7:0] a, input logic [7:0] d, output cor_rsp_t got);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk);
        req <= '{1'b0, 1'b1, a, ~d};
        @(posedge ref_clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
        #1 got = rsp;
    endtask
endmodule // cor_host_model
